// ### irq_pkg.sv
// package for the audio/peripheral secondary interrupt controller
// assumes a plain strobe register port, one 40 MHz clock
package irq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int AUDIO_N = 32;
  localparam int PERIPH_N = 12;
  // register offsets, byte addresses
  localparam logic [7:0] OFS_AUDIO_RISE   = 8'h00;
  localparam logic [7:0] OFS_AUDIO_FALL   = 8'h04;
  localparam logic [7:0] OFS_AUDIO_PRI    = 8'h08;
  localparam logic [7:0] OFS_AUDIO_HIGH   = 8'h0C;
  localparam logic [7:0] OFS_AUDIO_LOW    = 8'h10;
  localparam logic [7:0] OFS_AUDIO_HIGH_SH = 8'h14;
  localparam logic [7:0] OFS_AUDIO_LOW_SH = 8'h18;
  localparam logic [7:0] OFS_PERIPH_RISE  = 8'h1C;
  localparam logic [7:0] OFS_PERIPH_FALL  = 8'h20;
  localparam logic [7:0] OFS_PERIPH_LATCH = 8'h24;
  localparam logic [7:0] OFS_PERIPH_SH    = 8'h28;
  // sources that may use the falling edge
  localparam logic [31:0] AUDIO_FALL_OK  = 32'hFFC0_00FF;
  localparam logic [11:0] PERIPH_FALL_OK = 12'hFE0;
  // reset values: all audio sources low priority
  localparam logic [31:0] PRI_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // response latency of the interrupt lines
  localparam int LATENCY_CYC = 6;
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;
endpackage

// ### audio_periph_irq_controller.sv
// audio and peripheral group secondary interrupt controller
// assumes sources synchronous to clk, one-cycle strobes, no wait states
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module audio_periph_irq_controller #(
  parameter int LATENCY = irq_pkg::LATENCY_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // register port
  input  wire irq_pkg::reg_req_s          bus_req,
  output logic [irq_pkg::DATA_W-1:0]      rdata,
  // sources
  input  wire logic [irq_pkg::AUDIO_N-1:0]  audio_irq_channels,
  input  wire logic [irq_pkg::PERIPH_N-1:0] periph_irq_channels,
  // core requests
  output logic                            audio_high_irq,
  output logic                            audio_low_irq,
  output logic                            periph_irq
);
  import irq_pkg::*;

  // delay used by the line checks, follows the pipe depth
  localparam int LAT_D = LATENCY;
  localparam int PAD_W = DATA_W - PERIPH_N;

  // enable and priority registers
  logic [AUDIO_N-1:0]  audio_rise_edge_enable;
  logic [AUDIO_N-1:0]  audio_fall_edge_enable;
  logic [AUDIO_N-1:0]  audio_priority_select;
  logic [PERIPH_N-1:0] periph_rise_edge_enable;
  logic [PERIPH_N-1:0] periph_fall_edge_enable;
  // latches
  logic [AUDIO_N-1:0]  audio_high_pri_latch;
  logic [AUDIO_N-1:0]  audio_low_pri_latch;
  logic [PERIPH_N-1:0] periph_irq_latch;
  // edge history
  logic [AUDIO_N-1:0]  audio_prev;
  logic [PERIPH_N-1:0] periph_prev;
  // response pipes
  logic [LATENCY-1:0]  high_pipe;
  logic [LATENCY-1:0]  low_pipe;
  logic [LATENCY-1:0]  per_pipe;

  function automatic logic hit(input reg_req_s q, input logic [ADDR_W-1:0] ofs);
    return q.addr == ofs;
  endfunction

  // one source: rise against its enable, fall only where the source allows it
  function automatic logic edge_hit(input logic now, input logic was, input logic rise_en,
                                    input logic fall_en, input logic fall_ok);
    return (now & ~was & rise_en) | (~now & was & fall_en & fall_ok);
  endfunction

  // bus decode
  wire                wr          = bus_req.wr;
  wire                rd          = bus_req.rd;
  wire                sel_a_rise  = hit(bus_req, OFS_AUDIO_RISE);
  wire                sel_a_fall  = hit(bus_req, OFS_AUDIO_FALL);
  wire                sel_a_pri   = hit(bus_req, OFS_AUDIO_PRI);
  wire                sel_a_high  = hit(bus_req, OFS_AUDIO_HIGH);
  wire                sel_a_low   = hit(bus_req, OFS_AUDIO_LOW);
  wire                sel_a_hi_sh = hit(bus_req, OFS_AUDIO_HIGH_SH);
  wire                sel_a_lo_sh = hit(bus_req, OFS_AUDIO_LOW_SH);
  wire                sel_p_rise  = hit(bus_req, OFS_PERIPH_RISE);
  wire                sel_p_fall  = hit(bus_req, OFS_PERIPH_FALL);
  wire                sel_p_latch = hit(bus_req, OFS_PERIPH_LATCH);
  wire                sel_p_sh    = hit(bus_req, OFS_PERIPH_SH);

  // latches and shadows have no write strobe: read only
  wire                wr_a_rise   = wr && sel_a_rise;
  wire                wr_a_fall   = wr && sel_a_fall;
  wire                wr_a_pri    = wr && sel_a_pri;
  wire                wr_p_rise   = wr && sel_p_rise;
  wire                wr_p_fall   = wr && sel_p_fall;
  wire                rd_high     = rd && sel_a_high;
  wire                rd_low      = rd && sel_a_low;
  wire                rd_per      = rd && sel_p_latch;

  // qualified edges; history resets to zero, masks are zero then too
  wire [AUDIO_N-1:0]  audio_event;
  wire [PERIPH_N-1:0] periph_event;
  wire [AUDIO_N-1:0]  audio_rise  = audio_irq_channels & ~audio_prev;
  wire [PERIPH_N-1:0] periph_rise = periph_irq_channels & ~periph_prev;
  genvar gi;
  generate
    for (gi = 0; gi < AUDIO_N; gi++) begin : g_audio_edge
      assign audio_event[gi] = edge_hit(audio_irq_channels[gi], audio_prev[gi], audio_rise_edge_enable[gi],
                                        audio_fall_edge_enable[gi], AUDIO_FALL_OK[gi]);
    end
    for (gi = 0; gi < PERIPH_N; gi++) begin : g_periph_edge
      assign periph_event[gi] = edge_hit(periph_irq_channels[gi], periph_prev[gi], periph_rise_edge_enable[gi],
                                         periph_fall_edge_enable[gi], PERIPH_FALL_OK[gi]);
    end
  endgenerate

  wire [AUDIO_N-1:0]  high_set = audio_event & audio_priority_select;
  wire [AUDIO_N-1:0]  low_set  = audio_event & ~audio_priority_select;

  // set wins over the read clear, so a racing edge is not lost
  wire [AUDIO_N-1:0]  next_high = (rd_high ? '0 : audio_high_pri_latch) | high_set;
  wire [AUDIO_N-1:0]  next_low  = (rd_low ? '0 : audio_low_pri_latch) | low_set;
  wire [PERIPH_N-1:0] next_per  = (rd_per ? '0 : periph_irq_latch) | periph_event;

  wire [DATA_W-1:0]   next_rdata =
      sel_a_rise                 ? audio_rise_edge_enable :
      sel_a_fall                 ? audio_fall_edge_enable :
      sel_a_pri                  ? audio_priority_select :
      (sel_a_high || sel_a_hi_sh) ? audio_high_pri_latch :
      (sel_a_low || sel_a_lo_sh)  ? audio_low_pri_latch :
      sel_p_rise                 ? {{PAD_W{1'b0}}, periph_rise_edge_enable} :
      sel_p_fall                 ? {{PAD_W{1'b0}}, periph_fall_edge_enable} :
      (sel_p_latch || sel_p_sh)   ? {{PAD_W{1'b0}}, periph_irq_latch} :
      '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_rise_edge_enable <= MASK_RESET;
    end else if (wr_a_rise) begin
      audio_rise_edge_enable <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_fall_edge_enable <= MASK_RESET;
    end else if (wr_a_fall) begin
      audio_fall_edge_enable <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_priority_select <= PRI_RESET;
    end else if (wr_a_pri) begin
      audio_priority_select <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periph_rise_edge_enable <= MASK_RESET[PERIPH_N-1:0];
    end else if (wr_p_rise) begin
      periph_rise_edge_enable <= bus_req.wdata[PERIPH_N-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periph_fall_edge_enable <= MASK_RESET[PERIPH_N-1:0];
    end else if (wr_p_fall) begin
      periph_fall_edge_enable <= bus_req.wdata[PERIPH_N-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_high_pri_latch <= '0;
    end else begin
      audio_high_pri_latch <= next_high;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_low_pri_latch <= '0;
    end else begin
      audio_low_pri_latch <= next_low;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periph_irq_latch <= '0;
    end else begin
      periph_irq_latch <= next_per;
    end
  end

  // history resets to zero: a source high at release looks like a rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_prev  <= '0;
      periph_prev <= '0;
    end else begin
      audio_prev  <= audio_irq_channels;
      periph_prev <= periph_irq_channels;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? next_rdata : '0;
    end
  end

  // line follows the latch LATENCY cycles later, like the core's own path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      high_pipe <= '0;
      low_pipe  <= '0;
      per_pipe  <= '0;
    end else begin
      high_pipe <= {high_pipe[LATENCY-2:0], |audio_high_pri_latch};
      low_pipe  <= {low_pipe[LATENCY-2:0], |audio_low_pri_latch};
      per_pipe  <= {per_pipe[LATENCY-2:0], |periph_irq_latch};
    end
  end

  assign audio_high_irq = high_pipe[LATENCY-1];
  assign audio_low_irq  = low_pipe[LATENCY-1];
  assign periph_irq     = per_pipe[LATENCY-1];

  // assertions
  property p_high_latency;
    @(posedge clk) disable iff (sys_rst) (|audio_high_pri_latch) |-> ##LAT_D audio_high_irq;
  endproperty
  a_high_latency: assert property (p_high_latency) else $error("high line late");
  property p_low_line;
    @(posedge clk) disable iff (sys_rst) $past(|audio_low_pri_latch, LAT_D) |-> audio_low_irq;
  endproperty
  a_low_line: assert property (p_low_line) else $error("low line wrong");
  property p_per_line;
    @(posedge clk) disable iff (sys_rst) $past(|periph_irq_latch, LAT_D) == periph_irq;
  endproperty
  a_per_line: assert property (p_per_line) else $error("periph line wrong");
  property p_high_clear;
    @(posedge clk) disable iff (sys_rst) rd_high && !(|high_set) |=> audio_high_pri_latch == '0;
  endproperty
  a_high_clear: assert property (p_high_clear) else $error("high not cleared");
  property p_per_clear;
    @(posedge clk) disable iff (sys_rst) rd_per |=> periph_irq_latch == $past(periph_event);
  endproperty
  a_per_clear: assert property (p_per_clear) else $error("periph clear wrong");
  property p_shadow;
    @(posedge clk) disable iff (sys_rst)
      rd && sel_a_lo_sh |=> audio_low_pri_latch == ($past(audio_low_pri_latch) | $past(low_set));
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow read cleared");
  property p_keep_event;
    @(posedge clk) disable iff (sys_rst) |low_set |=> (audio_low_pri_latch & $past(low_set)) == $past(low_set);
  endproperty
  a_keep_event: assert property (p_keep_event) else $error("event lost");
  property p_priority;
    @(posedge clk) disable iff (sys_rst)
      |audio_event |=> (audio_high_pri_latch & ~$past(audio_priority_select) & $past(audio_event)) == '0;
  endproperty
  a_priority: assert property (p_priority) else $error("wrong latch");
  property p_no_fall_event;
    @(posedge clk) disable iff (sys_rst) ((audio_event & ~AUDIO_FALL_OK) & ~audio_rise) == '0;
  endproperty
  a_no_fall_event: assert property (p_no_fall_event) else $error("fall on event source");
  property p_high_line;
    @(posedge clk) disable iff (sys_rst) $past(|audio_high_pri_latch, LAT_D) == audio_high_irq;
  endproperty
  a_high_line: assert property (p_high_line) else $error("high line wrong");
  property p_low_clear;
    @(posedge clk) disable iff (sys_rst) rd_low && !(|low_set) |=> audio_low_pri_latch == '0;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low not cleared");
  property p_per_keep;
    @(posedge clk) disable iff (sys_rst) |periph_event |=> (periph_irq_latch & $past(periph_event)) == $past(periph_event);
  endproperty
  a_per_keep: assert property (p_per_keep) else $error("periph event lost");
  property p_rdata_idle;
    @(posedge clk) disable iff (sys_rst) !rd |=> rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_high_shadow;
    @(posedge clk) disable iff (sys_rst)
      rd && sel_a_hi_sh |=> audio_high_pri_latch == ($past(audio_high_pri_latch) | $past(high_set));
  endproperty
  a_high_shadow: assert property (p_high_shadow) else $error("high shadow read cleared");
  property p_per_shadow;
    @(posedge clk) disable iff (sys_rst)
      rd && sel_p_sh |=> periph_irq_latch == ($past(periph_irq_latch) | $past(periph_event));
  endproperty
  a_per_shadow: assert property (p_per_shadow) else $error("periph shadow read cleared");
  property p_per_rdata;
    @(posedge clk) disable iff (sys_rst) rd_per |=> rdata == {{PAD_W{1'b0}}, $past(periph_irq_latch)};
  endproperty
  a_per_rdata: assert property (p_per_rdata) else $error("periph latch read wrong");
  property p_per_no_fall;
    @(posedge clk) disable iff (sys_rst) ((periph_event & ~PERIPH_FALL_OK) & ~periph_rise) == '0;
  endproperty
  a_per_no_fall: assert property (p_per_no_fall) else $error("fall on rise-only periph source");
  c_high: cover property (@(posedge clk) audio_high_irq);
  c_low:  cover property (@(posedge clk) audio_low_irq);
  c_per:  cover property (@(posedge clk) periph_irq);
  c_race: cover property (@(posedge clk) rd_low && |low_set);
  c_high_clear: cover property (@(posedge clk) rd_high && |audio_high_pri_latch);
endmodule

// ### irq_core_model.sv
// model of the core primary interrupt latches fed by the controller
// assumes level requests synchronous to clk
`timescale 1ns/100ps
module irq_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // requests from the controller
  input  wire logic        audio_high_irq,
  input  wire logic        audio_low_irq,
  input  wire logic        periph_irq,
  // core latches, sticky until reset
  output logic [31:0]      core_irq_latch,
  output logic [31:0]      core_low_irq_latch
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_irq_latch     <= 32'h0000_0000;
      core_low_irq_latch <= 32'h0000_0000;
    end else begin
      core_irq_latch[11]    <= core_irq_latch[11] | audio_high_irq | periph_irq;
      core_low_irq_latch[6] <= core_low_irq_latch[6] | audio_low_irq;
    end
  end
endmodule

// ### tb_top.sv
// testbench for the audio/peripheral interrupt controller
// assumes the strobe register port and the core latch model
`timescale 1ns/100ps
module tb_top;
  import irq_pkg::*;
  logic              clk;
  logic              sys_rst;
  reg_req_s          bus_req;
  logic [DATA_W-1:0] rdata;
  logic [31:0]       audio_src;
  logic [11:0]       periph_src;
  logic              hi_irq;
  logic              lo_irq;
  logic              p_irq;
  logic [31:0]       core_latch;
  logic [31:0]       core_low_latch;
  int                n_mismatch;
  int                compares;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  audio_periph_irq_controller audio_periph_irq_controller_inst (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rdata(rdata), .audio_irq_channels(audio_src), .periph_irq_channels(periph_src), .audio_high_irq(hi_irq),
    .audio_low_irq(lo_irq), .periph_irq(p_irq));
  irq_core_model irq_core_model_inst (.clk(clk), .sys_rst(sys_rst), .audio_high_irq(hi_irq), .audio_low_irq(lo_irq),
    .periph_irq(p_irq), .core_irq_latch(core_latch), .core_low_irq_latch(core_low_latch));
  task automatic final_report();
    $display("mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 check("rdata", exp, rdata);
  endtask
  // new source levels, then count edges until the chosen line rises
  task automatic src(input logic [31:0] a, input logic [11:0] p, input logic [2:0] sel);
    int n;
    @(posedge clk);
    audio_src <= a;
    periph_src <= p;
    for (n = 1; n <= 20; n++) begin
      @(posedge clk);
      #1;
      if (({hi_irq, lo_irq, p_irq} & sel) != 3'b000) break;
    end
    check("latency", LATENCY_CYC + 1, n);
    if (n > 20) final_report();
  endtask
  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    audio_src = '0;
    periph_src = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_AUDIO_PRI, PRI_RESET);
    rd(OFS_AUDIO_RISE, MASK_RESET);
    rd(8'h3C, 32'h0000_0000);
    wr(OFS_AUDIO_RISE, 32'h0000_0401);
    wr(OFS_AUDIO_FALL, 32'h4000_0400);
    wr(OFS_AUDIO_PRI, 32'h4000_0000);
    wr(OFS_PERIPH_RISE, 32'h0000_0011);
    wr(OFS_PERIPH_FALL, 32'h0000_0030);
    // bit 30 rises with no rise enable, so nothing latches there
    src(32'h4000_0401, 12'h030, 3'b010);
    rd(OFS_AUDIO_LOW_SH, 32'h0000_0401);
    check("core low bit", 32'h0000_0040, core_low_latch);
    rd(OFS_AUDIO_FALL, 32'h4000_0400);
    rd(OFS_PERIPH_FALL, 32'h0000_0030);
    rd(OFS_AUDIO_LOW_SH, 32'h0000_0401);
    rd(OFS_AUDIO_LOW, 32'h0000_0401);
    rd(OFS_AUDIO_LOW_SH, 32'h0000_0000);
    rd(OFS_PERIPH_SH, 32'h0000_0010);
    rd(OFS_PERIPH_LATCH, 32'h0000_0010);
    rd(OFS_PERIPH_SH, 32'h0000_0000);
    repeat (8) @(posedge clk);
    check("low line", 32'h0, {31'h0, lo_irq});
    check("periph line", 32'h0, {31'h0, p_irq});
    // falling edges: bit 30 counts, bit 10 and periph bit 4 must not
    src(32'h0000_0000, 12'h000, 3'b100);
    rd(OFS_AUDIO_HIGH_SH, 32'h4000_0000);
    rd(OFS_AUDIO_LOW_SH, 32'h0000_0000);
    rd(OFS_PERIPH_SH, 32'h0000_0020);
    check("core high bit", 32'h0000_0800, core_latch);
    rd(OFS_AUDIO_HIGH, 32'h4000_0000);
    rd(OFS_AUDIO_HIGH_SH, 32'h0000_0000);
    rd(OFS_PERIPH_LATCH, 32'h0000_0020);
    repeat (8) @(posedge clk);
    #1 check("high line", 32'h0, {31'h0, hi_irq});
    check("periph line off", 32'h0, {31'h0, p_irq});
    final_report();
  end
endmodule
